// ===== verilog/pief_defs.vh
// register offsets, field positions and reset values of the peripheral interrupt block
`ifndef PIEF_DEFS_VH
`define PIEF_DEFS_VH
`define PIEF_ADDR_W 3
`define PIEF_OFS_ENABLE_1 3'h0
`define PIEF_OFS_ENABLE_2 3'h1
`define PIEF_OFS_REQUEST_1 3'h2
`define PIEF_OFS_CORE_CTRL 3'h3
`define PIEF_OFS_EVT_STATUS 3'h4
`define PIEF_OFS_EVT_MASK 3'h5
`define PIEF_OFS_SERIAL_DATA 3'h7
`define PIEF_RST_ENABLE_1 8'h00
`define PIEF_RST_ENABLE_2 8'h00
`define PIEF_RST_REQUEST_1 8'h00
`define PIEF_RST_CORE_CTRL 8'h00
`define PIEF_RST_EVT_MASK 8'h00
`define PIEF_EN2_IMPL_MASK 8'hF5
`define PIEF_RO_FLAG_MASK 8'h30
`define PIEF_BIT_EEPROM 7
`define PIEF_BIT_ADC 6
`define PIEF_BIT_RX 5
`define PIEF_BIT_TX 4
`define PIEF_BIT_SYNC 3
`define PIEF_BIT_CAPCOMP_A 2
`define PIEF_BIT_TIMER_B 1
`define PIEF_BIT_TIMER_A 0
`define PIEF_BIT_GLOBAL_GATE 7
`define PIEF_BIT_PERIPH_GATE 6
`define PIEF_CC_MODE_CAPTURE 2'h1
`define PIEF_CC_MODE_COMPARE 2'h2
`define PIEF_CC_MODE_PWM 2'h3
`endif

// ===== verilog/pief_flag_cell.v
// one sticky request flag: hardware set beats software clear
module pief_flag_cell (
    input wire clk,
    input wire rst,
    input wire set_pulse,
    input wire sw_write,
    input wire sw_value,
    output reg flag
);
    // set wins over a clear landing in the same cycle, so no event is lost
    always @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (sw_write) begin
            flag <= sw_value;
        end
    end
endmodule

// ===== verilog/pief_top.v
// peripheral interrupt enables, request flags and combined core request
//
// The address map and the address-and-strobe port were decided locally.
`include "pief_defs.vh"

// Functional notes
// [RULE1]: no peripheral request reaches the core unless the peripheral gate bit is set; evt_irq here follows evt_status and evt_mask with no gate
// [RULE2]: flags set on their condition whatever their own enable or global gate
// [RULE3]: software should clear a flag before setting its enable bit
// [RULE4]: enable register one: eeprom, adc, rx, tx, sync, capcomp a, timer b, timer a
// [RULE5]: enable register two: osc fail, comp b, comp a, display, low voltage, capcomp b
// [RULE6]: bits 3 and 1 of enable register two read zero and ignore writes
// [RULE7]: bit 7 flag set on eeprom write done, held until software writes zero
// [RULE8]: bit 6 flag set on adc conversion done, held until software clears
// [RULE9]: bit 5 read-only, high while rx buffer full, cleared by reading rx data
// [RULE10]: bit 4 read-only, high while tx buffer empty, cleared by writing tx data
// [RULE11]: bit 3 flag set on sync port transfer done, held until software clears
// [RULE12]: bit 2 flag set on capture unit one capture in capture mode
// [RULE13]: bit 2 flag set on compare match in compare mode, unused in pwm mode
// [RULE14]: bit 1 flag set on timer b period match, held until software clears
// [RULE15]: bit 0 flag set on timer a overflow, held until software clears
// [RULE16]: core request when both gates set and any enabled flag is set
module pief_top #(
    parameter ADDR_W = `PIEF_ADDR_W
) (
    input wire clk,
    input wire rst,
    input wire [ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire eeprom_done,
    input wire adc_done,
    input wire serial_rx_full,
    input wire serial_tx_empty,
    input wire sync_port_done,
    input wire [1:0] capcomp_a_mode,
    input wire capcomp_a_capture,
    input wire capcomp_a_match,
    input wire timer_b_match,
    input wire timer_a_ovf,
    output reg serial_rx_data_rd,
    output reg serial_tx_data_wr,
    output reg [7:0] periph_int_enable_2,
    output reg periph_irq,
    output reg evt_irq
);
    reg [7:0] periph_int_enable_1;
    reg [7:0] core_irq_control;
    reg [7:0] evt_status;
    reg [7:0] evt_mask;
    wire [7:0] flags;
    wire [7:0] set_vec;
    wire [7:0] pending;
    wire capcomp_a_evt;
    wire global_irq_gate;
    wire periph_irq_gate;
    wire req_wr;
    wire any_req;

    assign global_irq_gate = core_irq_control[`PIEF_BIT_GLOBAL_GATE];
    assign periph_irq_gate = core_irq_control[`PIEF_BIT_PERIPH_GATE];
    assign req_wr = wr_en && (addr == `PIEF_OFS_REQUEST_1);

    // capture/compare event depends on mode; pwm mode never raises the flag
    assign capcomp_a_evt = ((capcomp_a_mode == `PIEF_CC_MODE_CAPTURE) && capcomp_a_capture) // [RULE12]
        || ((capcomp_a_mode == `PIEF_CC_MODE_COMPARE) && capcomp_a_match); // [RULE13]

    // condition pulses, never gated by enables
    assign set_vec[`PIEF_BIT_EEPROM] = eeprom_done; // [RULE2] [RULE7]
    assign set_vec[`PIEF_BIT_ADC] = adc_done; // [RULE8]
    assign set_vec[`PIEF_BIT_RX] = 1'b0;
    assign set_vec[`PIEF_BIT_TX] = 1'b0;
    assign set_vec[`PIEF_BIT_SYNC] = sync_port_done; // [RULE11]
    assign set_vec[`PIEF_BIT_CAPCOMP_A] = capcomp_a_evt;
    assign set_vec[`PIEF_BIT_TIMER_B] = timer_b_match; // [RULE14]
    assign set_vec[`PIEF_BIT_TIMER_A] = timer_a_ovf; // [RULE15]

    // sticky flags for the six software-cleared sources
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_flag
            if (i == `PIEF_BIT_RX) begin : g_rx
                assign flags[i] = serial_rx_full; // [RULE9]
            end else if (i == `PIEF_BIT_TX) begin : g_tx
                assign flags[i] = serial_tx_empty; // [RULE10]
            end else begin : g_sticky
                pief_flag_cell u_cell (
                    .clk(clk),
                    .rst(rst),
                    .set_pulse(set_vec[i]),
                    .sw_write(req_wr),
                    .sw_value(wdata[i]),
                    .flag(flags[i])
                );
            end
        end
    endgenerate

    // flags meet their own enables; the gates then decide whether the core sees them
    assign pending = flags & periph_int_enable_1;
    assign any_req = |pending;

    // register writes; unimplemented enable bits stay zero
    always @(posedge clk) begin
        if (rst) begin
            periph_int_enable_1 <= `PIEF_RST_ENABLE_1;
            periph_int_enable_2 <= `PIEF_RST_ENABLE_2;
            core_irq_control <= `PIEF_RST_CORE_CTRL;
            evt_mask <= `PIEF_RST_EVT_MASK;
        end else if (wr_en) begin
            if (addr == `PIEF_OFS_ENABLE_1) begin
                periph_int_enable_1 <= wdata; // [RULE4]
            end else if (addr == `PIEF_OFS_ENABLE_2) begin
                periph_int_enable_2 <= wdata & `PIEF_EN2_IMPL_MASK; // [RULE5] [RULE6]
            end else if (addr == `PIEF_OFS_CORE_CTRL) begin
                core_irq_control <= wdata;
            end else if (addr == `PIEF_OFS_EVT_MASK) begin
                evt_mask <= wdata;
            end
        end
    end

    // event status collects the set pulses of the six sticky sources; write one clears, a new set wins
    always @(posedge clk) begin
        if (rst) begin
            evt_status <= 8'h00;
        end else begin
            evt_status <= (evt_status & ~((wr_en && addr == `PIEF_OFS_EVT_STATUS) ?
                wdata : 8'h00)) | set_vec;
        end
    end

    // combined request needs both gates; registered so the core sees a clean level
    always @(posedge clk) begin
        if (rst) begin
            periph_irq <= 1'b0;
            evt_irq <= 1'b0;
        end else begin
            periph_irq <= global_irq_gate && periph_irq_gate && any_req; // [RULE1] [RULE16]
            evt_irq <= |(evt_status & evt_mask);
        end
    end

    // side-effect strobes to the serial unit: read rx data clears full, write tx clears empty
    always @(posedge clk) begin
        if (rst) begin
            serial_rx_data_rd <= 1'b0;
            serial_tx_data_wr <= 1'b0;
        end else begin
            serial_rx_data_rd <= 1'b0;
            serial_tx_data_wr <= 1'b0;
            if (rd_en && addr == `PIEF_OFS_SERIAL_DATA) begin
                serial_rx_data_rd <= 1'b1; // [RULE9]
            end
            if (wr_en && addr == `PIEF_OFS_SERIAL_DATA) begin
                serial_tx_data_wr <= 1'b1; // [RULE10]
            end
        end
    end

    // read data valid the cycle after the strobe; unmapped reads return zero
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            if (addr == `PIEF_OFS_ENABLE_1) begin
                rdata <= periph_int_enable_1;
            end else if (addr == `PIEF_OFS_ENABLE_2) begin
                rdata <= periph_int_enable_2; // [RULE6]
            end else if (addr == `PIEF_OFS_REQUEST_1) begin
                rdata <= flags;
            end else if (addr == `PIEF_OFS_CORE_CTRL) begin
                rdata <= core_irq_control;
            end else if (addr == `PIEF_OFS_EVT_STATUS) begin
                rdata <= evt_status;
            end else if (addr == `PIEF_OFS_EVT_MASK) begin
                rdata <= evt_mask;
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

// ===== dv/pief_periph_model.sv
// peripheral side: condition pulses and serial buffer levels
module pief_periph_model (
    input wire clk,
    input wire serial_rx_data_rd,
    input wire serial_tx_data_wr,
    output logic [7:0] pulse = 8'h00,
    output logic serial_rx_full = 1'b0,
    output logic serial_tx_empty = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    // one-cycle pulses launched just after an edge, so the block samples them once
    task automatic fire(input logic [7:0] m);
        pulse <= m;
        @(posedge clk);
        pulse <= 8'h00;
    endtask
    // buffers change only on the data strobes; the bench refills them directly
    always @(posedge clk) begin
        if (serial_rx_data_rd)
            serial_rx_full <= 1'b0;
        if (serial_tx_data_wr)
            serial_tx_empty <= 1'b0;
    end
endmodule

// ===== dv/pief_assertions.sv
// port-level checks of the peripheral interrupt block
module pief_assertions #(
    parameter ADDR_W = 3
) (
    input wire clk,
    input wire rst,
    input wire [ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rdata,
    input wire serial_rx_full,
    input wire serial_tx_empty,
    input wire serial_rx_data_rd,
    input wire serial_tx_data_wr,
    input wire [7:0] periph_int_enable_2,
    input wire periph_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // read of the request register
    sequence s_req_read;
        rd_en && addr == 3'h2;
    endsequence
    // core control written with the peripheral gate off
    sequence s_gate_off;
        wr_en && addr == 3'h3 && !wdata[6];
    endsequence
    chk_gate_blocks_irq: assert property (s_gate_off |-> ##2 !periph_irq)
        else $error("core request despite closed gate");
    chk_rx_flag_level: assert property (
        s_req_read and $stable(serial_rx_full) |=> rdata[5] == $past(serial_rx_full))
        else $error("rx flag differs from buffer level");
    chk_tx_flag_level: assert property (
        s_req_read and $stable(serial_tx_empty) |=> rdata[4] == $past(serial_tx_empty))
        else $error("tx flag differs from buffer level");
    chk_rx_data_strobe: assert property (rd_en && addr == 3'h7 |=> serial_rx_data_rd)
        else $error("rx data read strobe missing");
    chk_tx_data_strobe: assert property (
        wr_en && addr == 3'h7 |=> serial_tx_data_wr ##1 !serial_tx_data_wr)
        else $error("tx data write strobe wrong");
    chk_en2_holes: assert property ((periph_int_enable_2 & 8'h0A) == 8'h00)
        else $error("unimplemented enable bits set");
    chk_en2_load: assert property (
        wr_en && addr == 3'h1 |=> periph_int_enable_2 == ($past(wdata) & 8'hF5))
        else $error("enable register two load wrong");
    chk_read_idle: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside read slot");
endmodule

bind pief_top pief_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== dv/pief_tb_top.sv
// self-checking bench for the peripheral interrupt block
module pief_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [1:0] capcomp_a_mode = 2'h1;
    logic [7:0] pulse, rdata, periph_int_enable_2;
    logic serial_rx_full, serial_tx_empty, serial_rx_data_rd, serial_tx_data_wr;
    logic periph_irq, evt_irq;
    int n_fail = 0, checked = 0;
    pief_top DUT (.*, .eeprom_done(pulse[7]), .adc_done(pulse[6]), .sync_port_done(pulse[3]),
        .capcomp_a_capture(pulse[5]), .capcomp_a_match(pulse[4]),
        .timer_b_match(pulse[1]), .timer_a_ovf(pulse[0]));
    pief_periph_model u_per (.*);
    // shared compare; x never matches
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // step off the edge so a following call never reassigns the strobe in this slot
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // request levels lag a register change by one cycle
    task automatic irq(input logic [1:0] exp);
        @(posedge clk);
        #1 chk({6'h00, evt_irq, periph_irq}, {6'h00, exp});
    endtask
    task automatic t_regs;
        rd(3'h2, 8'h10);
        wr(3'h0, 8'hA5);
        rd(3'h0, 8'hA5);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'hF5);
        rd(3'h6, 8'h00);
        wr(3'h0, 8'h00);
        $display("test regs done");
    endtask
    // every sticky source alone with enables and gates off, capture unit in all modes
    task automatic t_flags;
        logic [17:0] tab [10] = '{18'h18080, 18'h14040, 18'h10808, 18'h10202, 18'h10101,
            18'h12004, 18'h11000, 18'h21004, 18'h22000, 18'h33000};
        foreach (tab[i]) begin
            capcomp_a_mode <= tab[i][17:16];
            u_per.fire(tab[i][15:8]);
            rd(3'h2, tab[i][7:0] | 8'h10);
            wr(3'h2, 8'h00);
            rd(3'h2, 8'h10);
        end
        $display("test flags done");
    endtask
    task automatic t_serial;
        u_per.serial_rx_full <= 1'b1;
        wr(3'h2, 8'h00);
        rd(3'h2, 8'h30);
        rd(3'h7, 8'h00);
        wr(3'h2, 8'hFF);
        rd(3'h2, 8'hDF);
        wr(3'h7, 8'h55);
        wr(3'h2, 8'h00);
        rd(3'h2, 8'h00);
        u_per.serial_tx_empty <= 1'b1;
        $display("test serial done");
    endtask
    task automatic t_irq;
        wr(3'h2, 8'h00);
        wr(3'h0, 8'h01);
        wr(3'h3, 8'h80);
        u_per.fire(8'h01);
        irq(2'h0);
        wr(3'h3, 8'hC0);
        irq(2'h1);
        wr(3'h3, 8'h40);
        irq(2'h0);
        wr(3'h5, 8'h01);
        irq(2'h2);
        wr(3'h4, 8'hFF);
        irq(2'h0);
        $display("test irq done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    // the tests need about 70 cycles; this cuts a hang short
    initial begin
        #20000;
        n_fail++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_flags;
        t_serial;
        t_irq;
        final_report;
    end
endmodule
